// file: include/bzmel_defines.svh
// Offsets, field positions, reset values and timing counts of the buzzer melody controller
`ifndef BZMEL_DEFINES_SVH
`define BZMEL_DEFINES_SVH
`define BZMEL_OFF_A_FRQL   16'hA040
`define BZMEL_OFF_A_FRQH   16'hA041
`define BZMEL_OFF_A_DUR    16'hA042
`define BZMEL_OFF_A_PAU    16'hA043
`define BZMEL_OFF_B_FRQL   16'hA044
`define BZMEL_OFF_B_FRQH   16'hA045
`define BZMEL_OFF_B_DUR    16'hA046
`define BZMEL_OFF_B_PAU    16'hA047
`define BZMEL_OFF_CFG      16'hA048
`define BZMEL_OFF_POW      16'hA049
`define BZMEL_OFF_TU       16'hA04A
`define BZMEL_OFF_IRQ_STAT 16'hA050
`define BZMEL_OFF_IRQ_CLR  16'hA051
`define BZMEL_OFF_IRQ_EN   16'hA052
`define BZMEL_RESET_BYTE   8'h00
`define BZMEL_BIT_EN       7
`define BZMEL_BIT_POL      6
`define BZMEL_BIT_IENB     5
`define BZMEL_BIT_IENA     4
`define BZMEL_BIT_IFB      3
`define BZMEL_BIT_IFA      2
`define BZMEL_BIT_GOB      1
`define BZMEL_BIT_GOA      0
`define BZMEL_BIT_PPONG    2
`define BZMEL_BIT_TONE_BASE_SELECT    4
`define BZMEL_BIT_IEPOW    1
`define BZMEL_BIT_IFPOW    0
`define BZMEL_CLK_HZ       20000000
`define BZMEL_SOSC_HZ      32000
`define BZMEL_SOSC_CYC     (`BZMEL_CLK_HZ / `BZMEL_SOSC_HZ)
`define BZMEL_MS_TICKS     32
`define BZMEL_BASE_DIV0    32
`define BZMEL_BASE_DIV1    64
`endif

// file: include/bzmel_pkg.sv
// Types of the buzzer melody controller
package bzmel_pkg;
	typedef enum logic [1:0] {BZMEL_IDLE, BZMEL_TONE, BZMEL_GAP} bzmel_state_t;
endpackage

// file: logic/bzmel_top.sv
// Buzzer and melody controller with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "bzmel_defines.svh"

// Overview of operation
// - Two note slots, each divider, length, gap
// - Play notes once, or alternate in ping-pong
// - Tone equals base divided by twice (divider plus one)
// - Tone divider is twelve bits wide
// - Tone lasts time step times length
// - Gap lasts time step times gap count
// - Time step select 1, 2, 4, 8 ms
// - Power timer starts on either note start
// - Power expiry sets flag, interrupt if enabled
// - Power output active while window runs
// - Write 1 starts note, self-clears at end unless ping-pong
// - Both starts together play A then B
// - End flag set if enabled, cleared by 0
// - Busy bit while note actively plays
module bzmel_top #(
	parameter int SOSC_CYC = `BZMEL_SOSC_CYC
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RESET,
	input  wire logic [15:0] I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	input  wire logic [3:0]  I_AVS_BYTEENABLE,
	output logic      [31:0] O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	output logic             O_BUZZER,
	output logic             O_POWER_EN,
	output logic             O_IRQ
);
	localparam int SW = $clog2(SOSC_CYC + 1);

	logic [7:0]  freq_lo_q [2];
	logic [3:0]  freq_hi_q [2];
	logic [7:0]  length_q [2];
	logic [7:0]  gap_q [2];
	logic [7:0]  power_window_length_q;
	logic [1:0]  time_step_select_q;
	logic        ping_pong_q;
	logic        tone_base_select_q;
	logic        power_window_irq_enable_q;
	logic        power_window_irq_flag_q;
	logic        enable_q;
	logic        polarity_q;
	logic [1:0]  end_irq_enable_q;
	logic [1:0]  end_flag_q;
	logic [1:0]  go_q;
	logic [2:0]  irq_en_q;
	logic        ack_q;
	logic [31:0] rdata_q;

	bzmel_pkg::bzmel_state_t state_q;
	logic        slot_q;
	logic [SW-1:0] sosc_cnt_q;
	logic [5:0]  ms_cnt_q;
	logic [2:0]  step_cnt_q;
	logic [7:0]  seg_cnt_q;
	logic [7:0]  pow_cnt_q;
	logic        pow_run_q;
	logic [5:0]  base_cnt_q;
	logic [11:0] tone_cnt_q;
	logic        tone_q;

	// Bus decode; one idle waitrequest cycle then a one-cycle acknowledge
	wire        req      = I_AVS_READ | I_AVS_WRITE;
	wire        wr_fire  = I_AVS_WRITE & ack_q;
	wire        lane0    = I_AVS_BYTEENABLE[0];
	wire [7:0]  wd       = I_AVS_WRITEDATA[7:0];
	wire        wr_byte  = wr_fire & lane0;
	assign O_AVS_WAITREQUEST = req & ~ack_q;
	assign O_AVS_READDATA    = rdata_q;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		return a == off;
	endfunction

	// Time base: slow oscillator tick, then ms tick, then selected step
	wire sosc_tick  = (sosc_cnt_q == SW'(SOSC_CYC - 1));
	wire ms_tick    = sosc_tick & (ms_cnt_q == 6'(`BZMEL_MS_TICKS - 1));
	wire [2:0] step_max = 3'((4'h1 << time_step_select_q) - 4'h1);
	wire step_tick  = ms_tick & (step_cnt_q == step_max);

	// Tone base prescaler and 12-bit divider
	wire [5:0] base_max = tone_base_select_q ? 6'(`BZMEL_BASE_DIV1 - 1)
	                                         : 6'(`BZMEL_BASE_DIV0 - 1);
	wire base_tick  = (base_cnt_q == base_max);
	wire [11:0] div_sel = {freq_hi_q[slot_q], freq_lo_q[slot_q]};
	wire tone_tick  = base_tick & (tone_cnt_q == div_sel);

	// Sequencing decisions
	wire start_any  = wr_byte & hit(I_AVS_ADDRESS, `BZMEL_OFF_CFG)
	                  & (wd[`BZMEL_BIT_GOA] | wd[`BZMEL_BIT_GOB]);
	wire seg_done   = step_tick & (seg_cnt_q <= 8'h01);
	wire tone_end   = (state_q == bzmel_pkg::BZMEL_TONE)
	                  & ((length_q[slot_q] == 8'h00) | seg_done);
	wire gap_end    = (state_q == bzmel_pkg::BZMEL_GAP)
	                  & ((gap_q[slot_q] == 8'h00) | seg_done);
	wire other_go   = go_q[~slot_q];
	wire [1:0] note_done = gap_end ? (slot_q ? 2'b10 : 2'b01) : 2'b00;
	wire pow_expire = pow_run_q & step_tick & (pow_cnt_q <= 8'h01);
	wire [2:0] events = {pow_expire, note_done};

	// Register writes; only byte lane 0 of the write data is used
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			for (int i = 0; i < 2; i++) begin
				freq_lo_q[i] <= `BZMEL_RESET_BYTE;
				freq_hi_q[i] <= 4'h0;
				length_q[i]  <= `BZMEL_RESET_BYTE;
				gap_q[i]     <= `BZMEL_RESET_BYTE;
			end
			power_window_length_q     <= `BZMEL_RESET_BYTE;
			time_step_select_q        <= 2'h0;
			ping_pong_q               <= 1'b0;
			tone_base_select_q        <= 1'b0;
			power_window_irq_enable_q <= 1'b0;
			enable_q                  <= 1'b0;
			polarity_q                <= 1'b0;
			end_irq_enable_q          <= 2'h0;
			irq_en_q                  <= 3'h0;
		end else if (wr_byte) begin
			if (hit(I_AVS_ADDRESS, `BZMEL_OFF_A_FRQL)) freq_lo_q[0] <= wd;
			if (hit(I_AVS_ADDRESS, `BZMEL_OFF_A_FRQH)) freq_hi_q[0] <= wd[3:0];
			if (hit(I_AVS_ADDRESS, `BZMEL_OFF_A_DUR))  length_q[0]  <= wd;
			if (hit(I_AVS_ADDRESS, `BZMEL_OFF_A_PAU))  gap_q[0]     <= wd;
			if (hit(I_AVS_ADDRESS, `BZMEL_OFF_B_FRQL)) freq_lo_q[1] <= wd;
			if (hit(I_AVS_ADDRESS, `BZMEL_OFF_B_FRQH)) freq_hi_q[1] <= wd[3:0];
			if (hit(I_AVS_ADDRESS, `BZMEL_OFF_B_DUR))  length_q[1]  <= wd;
			if (hit(I_AVS_ADDRESS, `BZMEL_OFF_B_PAU))  gap_q[1]     <= wd;
			if (hit(I_AVS_ADDRESS, `BZMEL_OFF_POW))    power_window_length_q <= wd;
			if (hit(I_AVS_ADDRESS, `BZMEL_OFF_TU)) begin
				time_step_select_q        <= wd[7:6];
				tone_base_select_q        <= wd[`BZMEL_BIT_TONE_BASE_SELECT];
				ping_pong_q               <= wd[`BZMEL_BIT_PPONG];
				power_window_irq_enable_q <= wd[`BZMEL_BIT_IEPOW];
			end
			if (hit(I_AVS_ADDRESS, `BZMEL_OFF_CFG)) begin
				enable_q         <= wd[`BZMEL_BIT_EN];
				polarity_q       <= wd[`BZMEL_BIT_POL];
				end_irq_enable_q <= wd[`BZMEL_BIT_IENB:`BZMEL_BIT_IENA];
			end
			if (hit(I_AVS_ADDRESS, `BZMEL_OFF_IRQ_EN)) irq_en_q <= wd[2:0];
		end
	end

	// Sticky flags: end flags, power flag and status bits, hardware set wins
	logic [2:0] irq_stat_q;
	wire  clr_stat = wr_byte & hit(I_AVS_ADDRESS, `BZMEL_OFF_IRQ_CLR);
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			end_flag_q              <= 2'h0;
			power_window_irq_flag_q <= 1'b0;
			irq_stat_q              <= 3'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (note_done[i] & end_irq_enable_q[i])
					end_flag_q[i] <= 1'b1;
				else if (wr_byte & hit(I_AVS_ADDRESS, `BZMEL_OFF_CFG) & ~wd[2+i])
					end_flag_q[i] <= 1'b0;
			end
			if (pow_expire)
				power_window_irq_flag_q <= 1'b1;
			else if (wr_byte & hit(I_AVS_ADDRESS, `BZMEL_OFF_TU) & ~wd[`BZMEL_BIT_IFPOW])
				power_window_irq_flag_q <= 1'b0;
			irq_stat_q <= events | (irq_stat_q & ~(clr_stat ? wd[2:0] : 3'h0));
		end
	end

	// Start commands: write 1 sets, write 0 ignored, self clear at note end unless ping-pong and enabled
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			go_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (start_any & wd[i])
					go_q[i] <= 1'b1;
				else if (note_done[i] & ~(ping_pong_q & enable_q))
					go_q[i] <= 1'b0;
			end
		end
	end

	// Sequencer: tone, gap, then other slot if pending or ping-pong
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			state_q   <= bzmel_pkg::BZMEL_IDLE;
			slot_q    <= 1'b0;
			seg_cnt_q <= 8'h00;
		end else if (~enable_q) begin
			state_q <= bzmel_pkg::BZMEL_IDLE;
		end else begin
			case (state_q)
				bzmel_pkg::BZMEL_IDLE: begin
					if (go_q != 2'h0) begin
						slot_q    <= ~go_q[0];
						seg_cnt_q <= go_q[0] ? length_q[0] : length_q[1];
						state_q   <= bzmel_pkg::BZMEL_TONE;
					end
				end
				bzmel_pkg::BZMEL_TONE: begin
					if (tone_end) begin
						seg_cnt_q <= gap_q[slot_q];
						state_q   <= bzmel_pkg::BZMEL_GAP;
					end else if (step_tick) begin
						seg_cnt_q <= seg_cnt_q - 8'h01;
					end
				end
				bzmel_pkg::BZMEL_GAP: begin
					if (gap_end) begin
						if (other_go | ping_pong_q) begin
							slot_q    <= ~slot_q;
							seg_cnt_q <= length_q[~slot_q];
							state_q   <= bzmel_pkg::BZMEL_TONE;
						end else begin
							state_q <= bzmel_pkg::BZMEL_IDLE;
						end
					end else if (step_tick) begin
						seg_cnt_q <= seg_cnt_q - 8'h01;
					end
				end
				default: state_q <= bzmel_pkg::BZMEL_IDLE;
			endcase
		end
	end

	// Time base counters; step counter resyncs on a start for clean first step
	always_ff @(posedge I_CLK) begin
		if (I_RESET | start_any) begin
			sosc_cnt_q <= '0;
			ms_cnt_q   <= 6'h00;
			step_cnt_q <= 3'h0;
		end else begin
			sosc_cnt_q <= sosc_tick ? '0 : sosc_cnt_q + SW'(1);
			if (sosc_tick)
				ms_cnt_q <= ms_tick ? 6'h00 : ms_cnt_q + 6'h01;
			if (ms_tick)
				step_cnt_q <= step_tick ? 3'h0 : step_cnt_q + 3'h1;
		end
	end

	// Power window timer
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			pow_run_q <= 1'b0;
			pow_cnt_q <= 8'h00;
		end else if (start_any) begin
			pow_run_q <= power_window_length_q != 8'h00;
			pow_cnt_q <= power_window_length_q;
		end else if (pow_run_q & step_tick) begin
			pow_cnt_q <= pow_cnt_q - 8'h01;
			if (pow_expire)
				pow_run_q <= 1'b0;
		end
	end

	// Tone generator; toggles each divider wrap so output is half that rate
	always_ff @(posedge I_CLK) begin
		if (I_RESET | (state_q != bzmel_pkg::BZMEL_TONE)) begin
			base_cnt_q <= 6'h00;
			tone_cnt_q <= 12'h000;
			tone_q     <= 1'b0;
		end else begin
			base_cnt_q <= base_tick ? 6'h00 : base_cnt_q + 6'h01;
			if (base_tick)
				tone_cnt_q <= tone_tick ? 12'h000 : tone_cnt_q + 12'h001;
			if (tone_tick)
				tone_q <= ~tone_q;
		end
	end

	// Read mux; unmapped addresses read zero
	wire [1:0] playing = (state_q == bzmel_pkg::BZMEL_TONE) ?
	                     (slot_q ? 2'b10 : 2'b01) : 2'b00;
	wire [7:0] cfg_rd = {enable_q, polarity_q, end_irq_enable_q, end_flag_q, playing};
	wire [7:0] tu_rd  = {time_step_select_q, 1'b0, tone_base_select_q, 1'b0,
	                     ping_pong_q, power_window_irq_enable_q, power_window_irq_flag_q};
	logic [7:0] rd_byte;
	always_comb begin
		case (I_AVS_ADDRESS)
			`BZMEL_OFF_A_FRQL:   rd_byte = freq_lo_q[0];
			`BZMEL_OFF_A_FRQH:   rd_byte = {4'h0, freq_hi_q[0]};
			`BZMEL_OFF_A_DUR:    rd_byte = length_q[0];
			`BZMEL_OFF_A_PAU:    rd_byte = gap_q[0];
			`BZMEL_OFF_B_FRQL:   rd_byte = freq_lo_q[1];
			`BZMEL_OFF_B_FRQH:   rd_byte = {4'h0, freq_hi_q[1]};
			`BZMEL_OFF_B_DUR:    rd_byte = length_q[1];
			`BZMEL_OFF_B_PAU:    rd_byte = gap_q[1];
			`BZMEL_OFF_CFG:      rd_byte = cfg_rd;
			`BZMEL_OFF_POW:      rd_byte = power_window_length_q;
			`BZMEL_OFF_TU:       rd_byte = tu_rd;
			`BZMEL_OFF_IRQ_STAT: rd_byte = {5'h00, irq_stat_q};
			`BZMEL_OFF_IRQ_EN:   rd_byte = {5'h00, irq_en_q};
			default:             rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q   <= req & ~ack_q;
			rdata_q <= (I_AVS_READ & ~ack_q) ? {24'h000000, rd_byte} : rdata_q;
		end
	end

	// Outputs registered; buzzer inactive level equals the polarity bit
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_BUZZER   <= 1'b0;
			O_POWER_EN <= 1'b0;
			O_IRQ      <= 1'b0;
		end else begin
			O_BUZZER   <= (tone_q & (state_q == bzmel_pkg::BZMEL_TONE)) ^ polarity_q;
			O_POWER_EN <= pow_run_q;
			O_IRQ      <= (|(irq_stat_q & irq_en_q))
			              | (power_window_irq_flag_q & power_window_irq_enable_q)
			              | (|end_flag_q);
		end
	end

	// Invariants of the sequencer, the sticky flags and the bus answer
	a_tone_only_play: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(state_q != bzmel_pkg::BZMEL_TONE) |=> (O_BUZZER == $past(polarity_q)))
		else $error("buzzer not inactive outside tone");
	a_pow_start_run: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(start_any && power_window_length_q != 8'h00) |=> pow_run_q ##1 O_POWER_EN)
		else $error("power window did not start");
	a_pow_flag_set: assert property (@(posedge I_CLK) disable iff (I_RESET)
		pow_expire |=> power_window_irq_flag_q)
		else $error("power flag not set on expiry");
	a_pow_flag_sticky: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(power_window_irq_flag_q && !(wr_byte && hit(I_AVS_ADDRESS, `BZMEL_OFF_TU)))
		|=> power_window_irq_flag_q)
		else $error("power flag dropped");
	a_end_flag_set: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(note_done[0] && end_irq_enable_q[0]) |=> end_flag_q[0])
		else $error("note a end flag not set");
	a_go_ignores_zero: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(!go_q[0] && !(start_any && wd[0])) |=> !go_q[0])
		else $error("start bit set without write one");
	a_a_before_b: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(state_q == bzmel_pkg::BZMEL_IDLE && enable_q && go_q == 2'b11) |=> !slot_q)
		else $error("note b played before a");
	a_busy_matches: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(playing != 2'b00) |-> (go_q != 2'b00))
		else $error("busy without a pending start");
	a_wait_one: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(req && !ack_q) |=> !O_AVS_WAITREQUEST)
		else $error("bus answer late");

	// Coverage of the main play and interrupt scenarios
	c_a_then_b: cover property (@(posedge I_CLK) disable iff (I_RESET)
		state_q == bzmel_pkg::BZMEL_IDLE && enable_q && go_q == 2'b11);
	c_tone_gap: cover property (@(posedge I_CLK) disable iff (I_RESET)
		state_q == bzmel_pkg::BZMEL_TONE ##1 state_q == bzmel_pkg::BZMEL_GAP);
	c_slot_swap: cover property (@(posedge I_CLK) disable iff (I_RESET)
		gap_end && (other_go || ping_pong_q));
	c_pow_expire: cover property (@(posedge I_CLK) disable iff (I_RESET) pow_expire);
	c_irq_out: cover property (@(posedge I_CLK) disable iff (I_RESET) O_IRQ);
endmodule
`default_nettype wire

// file: bench/bzmel_buzzer_model.sv
// Buzzer element and power switch model that times the tone and the power pulse
`timescale 1ns/1ps
`default_nettype none
module bzmel_buzzer_model (
	input  wire logic i_clk,
	input  wire logic i_tone,
	input  wire logic i_power,
	output var int    o_half,
	output var int    o_window
);
	int   cnt_tone = 0;
	int   last_tone = 0;
	int   cnt_pow = 0;
	logic tone_q = 1'b0;
	// A half period counts only when two edges in a row agree, so a cut-off tail is ignored
	always @(posedge i_clk) begin
		tone_q <= i_tone;
		cnt_tone <= (tone_q != i_tone) ? 1 : cnt_tone + 1;
		if (tone_q != i_tone) begin
			if (cnt_tone == last_tone) o_half <= cnt_tone;
			last_tone <= cnt_tone;
		end
		cnt_pow <= i_power ? cnt_pow + 1 : 0;
		if (!i_power && cnt_pow != 0) o_window <= cnt_pow;
	end
endmodule
`default_nettype wire

// file: bench/bzmel_top_test.sv
// Self-checking bench of the buzzer melody controller
`timescale 1ns/1ps
`default_nettype none
`include "bzmel_defines.svh"
module bzmel_top_test;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] adr = 16'h0000;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [3:0]  be = 4'hF;
	logic [31:0] rdat;
	logic        wait_req;
	logic        buz;
	logic        pwr;
	logic        irq;
	logic [7:0]  q;
	int          half;
	int          window;
	int          errors = 0;
	int          tests_run = 0;

	// Short time step: one millisecond becomes 64 cycles
	bzmel_top #(.SOSC_CYC(2)) u_bzmel_top (
		.I_CLK(clk), .I_RESET(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
		.I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(be),
		.O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wait_req), .O_BUZZER(buz),
		.O_POWER_EN(pwr), .O_IRQ(irq)
	);
	bzmel_buzzer_model u_bzmel_buzzer_model (
		.i_clk(clk), .i_tone(buz), .i_power(pwr), .o_half(half), .o_window(window)
	);

	always #25 clk = ~clk;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One transfer; the request stands until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 50);
		if (n >= 50) chk("waitrequest", 1'b1, 1'b0);
		// Read data is taken at the very edge that sees waitrequest low
		q = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		// Two more edges so that outputs registered after the access have settled
		repeat (2) @(posedge clk);
	endtask

	task automatic rdchk(input string nm, input logic [15:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(nm, q, e);
	endtask

	// Polls one register bit with a bounded count, returns elapsed cycles
	task automatic poll(input logic [15:0] a, input int b, input logic v, output int t);
		time t0;
		t0 = $time;
		repeat (400) begin
			bus(1'b0, a, 8'h00);
			if (q[b] === v) break;
		end
		t = int'(($time - t0) / 50);
		chk("polled bit", q[b], v);
	endtask

	task automatic t_regs();
		chk("idle outputs", {buz, pwr, irq}, 3'b000);
		for (int i = 0; i < 11; i++) begin
			rdchk("reset value", 16'hA040 + 16'(i), 8'h00);
		end
		bus(1'b1, `BZMEL_OFF_A_FRQL, 8'h5A);
		rdchk("freq low", `BZMEL_OFF_A_FRQL, 8'h5A);
		bus(1'b1, `BZMEL_OFF_B_FRQH, 8'hFF);
		rdchk("freq high", `BZMEL_OFF_B_FRQH, 8'h0F);
		be <= 4'h0;
		bus(1'b1, `BZMEL_OFF_B_DUR, 8'h33);
		be <= 4'hF;
		rdchk("masked write", `BZMEL_OFF_B_DUR, 8'h00);
		bus(1'b1, 16'hA04B, 8'h77);
		rdchk("unmapped", 16'hA04B, 8'h00);
		$display("test regs done");
	endtask

	// Plays note A once with end interrupt on and times tone and note
	task automatic t_tone(input logic [11:0] f, input logic tb, input logic [7:0] d, input int hp);
		int t;
		bus(1'b1, `BZMEL_OFF_A_FRQL, f[7:0]);
		bus(1'b1, `BZMEL_OFF_A_FRQH, {4'h0, f[11:8]});
		bus(1'b1, `BZMEL_OFF_A_DUR, d);
		bus(1'b1, `BZMEL_OFF_A_PAU, 8'h01);
		bus(1'b1, `BZMEL_OFF_TU, {3'b000, tb, 4'h0});
		bus(1'b1, `BZMEL_OFF_CFG, 8'h91);
		poll(`BZMEL_OFF_CFG, 2, 1'b1, t);
		chk("half period", half, hp);
		chk("note time", t > (d + 1) * 64 - 10 && t < (d + 1) * 64 + 10, 1'b1);
		chk("end irq", irq, 1'b1);
		chk("idle after note", {q[1:0], buz}, 3'b000);
		bus(1'b1, `BZMEL_OFF_CFG, 8'h90);
		rdchk("flag cleared", `BZMEL_OFF_CFG, 8'h90);
		chk("irq dropped", irq, 1'b0);
		$display("test tone done");
	endtask

	task automatic t_both();
		int t;
		bus(1'b1, `BZMEL_OFF_B_FRQL, 8'h03);
		bus(1'b1, `BZMEL_OFF_B_DUR, 8'h02);
		bus(1'b1, `BZMEL_OFF_CFG, 8'h83);
		rdchk("A plays first", `BZMEL_OFF_CFG, 8'h81);
		poll(`BZMEL_OFF_CFG, 1, 1'b1, t);
		chk("A done before B", q[0], 1'b0);
		poll(`BZMEL_OFF_CFG, 1, 1'b0, t);
		chk("no end flags", {q[3:2], irq}, 3'b000);
		$display("test both done");
	endtask

	// Power window, its sticky flag and the status, enable and clear registers
	task automatic t_power();
		int t;
		bus(1'b1, `BZMEL_OFF_A_DUR, 8'h01);
		bus(1'b1, `BZMEL_OFF_A_PAU, 8'h00);
		bus(1'b1, `BZMEL_OFF_POW, 8'h01);
		bus(1'b1, `BZMEL_OFF_TU, 8'h40);
		bus(1'b1, `BZMEL_OFF_CFG, 8'h81);
		poll(`BZMEL_OFF_TU, 0, 1'b1, t);
		chk("power window", window > 123 && window < 133, 1'b1);
		chk("irq masked", irq, 1'b0);
		bus(1'b1, `BZMEL_OFF_IRQ_EN, 8'h04);
		chk("status irq", irq, 1'b1);
		bus(1'b1, `BZMEL_OFF_IRQ_CLR, 8'h04);
		bus(1'b0, `BZMEL_OFF_IRQ_STAT, 8'h00);
		chk("status cleared", {q[2], irq}, 2'b00);
		bus(1'b1, `BZMEL_OFF_TU, 8'h43);
		chk("power irq", irq, 1'b1);
		bus(1'b1, `BZMEL_OFF_TU, 8'h42);
		rdchk("power flag cleared", `BZMEL_OFF_TU, 8'h42);
		chk("power irq off", irq, 1'b0);
		bus(1'b1, `BZMEL_OFF_CFG, 8'h82);
		poll(`BZMEL_OFF_TU, 0, 1'b1, t);
		chk("flag set again", irq, 1'b1);
		bus(1'b1, `BZMEL_OFF_TU, 8'h00);
		bus(1'b1, `BZMEL_OFF_IRQ_EN, 8'h00);
		// Let note B finish so that the next test starts from idle
		poll(`BZMEL_OFF_CFG, 1, 1'b0, t);
		$display("test power done");
	endtask

	task automatic t_pingpong();
		int t;
		bus(1'b1, `BZMEL_OFF_TU, 8'h04);
		bus(1'b1, `BZMEL_OFF_CFG, 8'h81);
		poll(`BZMEL_OFF_CFG, 1, 1'b1, t);
		poll(`BZMEL_OFF_CFG, 0, 1'b1, t);
		bus(1'b1, `BZMEL_OFF_CFG, 8'h00);
		bus(1'b1, `BZMEL_OFF_TU, 8'h00);
		$display("test pingpong done");
	endtask

	// Inverted polarity must show as a high idle level
	task automatic t_pol();
		bus(1'b1, `BZMEL_OFF_CFG, 8'h40);
		chk("idle inverted", buz, 1'b1);
		bus(1'b1, `BZMEL_OFF_CFG, 8'h00);
		chk("idle normal", buz, 1'b0);
		$display("test polarity done");
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog sized well above the longest expected run
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		$display("watchdog expired");
		end_sim();
	end

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_tone(12'h000, 1'b0, 8'h04, 32);
		t_tone(12'h001, 1'b1, 8'h08, 128);
		t_both();
		t_power();
		t_pingpong();
		t_pol();
		end_sim();
	end
endmodule
`default_nettype wire
